// *** core/ldp_master.sv ***
`timescale 1ns/100ps
module ldp_master
   import ldp_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   ldp_if.host bus, // Serial link
   input wire logic [1:0] cmd_addr, // Command register address
   input wire logic [15:0] cmd_wdata, // Write data
   input wire logic cmd_wr, // Write strobe
   input wire logic cmd_rd, // Read strobe
   output logic [15:0] cmd_rdata // Read data, one cycle later
);
   import ldp_pkg::*;
   // Control write: bit 15 read, 14:8 pointer bits 7:1, 7:0 data; pointer bit 0 is always 0
   typedef enum logic [2:0] {
      LDP_M_IDLE = 3'h0,
      LDP_M_START = 3'h1,
      LDP_M_BIT = 3'h2,
      LDP_M_RSTART = 3'h3,
      LDP_M_STOP = 3'h4
   } ldp_m_st_t;
   ldp_m_st_t st_reg;
   logic [7:0] div_reg;
   logic [1:0] ph_reg;
   logic [3:0] bit_reg;
   logic [1:0] byte_reg;
   logic [7:0] tx_reg, rx_reg, rdat_reg, ptr_reg, dat_reg;
   logic rd_reg, nack_reg, scl_reg, sda_reg;
   logic [1:0] sda_sync_reg;
   wire tick = div_reg == 8'h0;
   wire go = cmd_wr && cmd_addr == LDP_CMD_CTRL && st_reg == LDP_M_IDLE;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_rdata <= 16'h0000;
      end else if (cmd_rd) begin
         case (cmd_addr)
            LDP_CMD_STAT: cmd_rdata <= {14'h0000, nack_reg, st_reg != LDP_M_IDLE};
            LDP_CMD_RDAT: cmd_rdata <= {8'h00, rdat_reg};
            default: cmd_rdata <= 16'h0000;
         endcase
      end else begin
         cmd_rdata <= 16'h0000;
      end
   end
   // Four phases per link bit, each a quarter of the link period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= LDP_M_IDLE;
         div_reg <= 8'h0;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         byte_reg <= 2'h0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
         rdat_reg <= 8'h00;
         ptr_reg <= 8'h00;
         dat_reg <= 8'h00;
         rd_reg <= 1'b0;
         nack_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else if (go) begin
         rd_reg <= cmd_wdata[15];
         ptr_reg <= {cmd_wdata[14:8], 1'b0};
         dat_reg <= cmd_wdata[7:0];
         nack_reg <= 1'b0;
         byte_reg <= 2'h0;
         st_reg <= LDP_M_START;
         ph_reg <= 2'h0;
         div_reg <= LDP_HALF_CYC / 8'h2;
      end else if (st_reg != LDP_M_IDLE) begin
         div_reg <= tick ? (LDP_HALF_CYC / 8'h2) - 8'h1 : div_reg - 8'h1;
         if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (st_reg)
               LDP_M_START, LDP_M_RSTART: begin
                  case (ph_reg)
                     2'h0: sda_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b0;
                     default: begin
                        scl_reg <= 1'b0;
                        st_reg <= LDP_M_BIT;
                        bit_reg <= 4'h0;
                        tx_reg <= {LDP_TARGET_ADDR, st_reg == LDP_M_RSTART};
                     end
                  endcase
               end
               LDP_M_BIT: begin
                  case (ph_reg)
                     2'h0: begin
                        // Drive while SCL low release on ack or read bits
                        sda_reg <= (bit_reg == 4'h8 || byte_reg == 2'h3) ? 1'b1 : tx_reg[7];
                     end
                     2'h1: scl_reg <= 1'b1;
                     2'h2: begin
                        if (bit_reg == 4'h8 && byte_reg != 2'h3) begin
                           nack_reg <= nack_reg | sda_sync_reg[1];
                        end else if (bit_reg != 4'h8) begin
                           rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                        end
                     end
                     default: begin
                        scl_reg <= 1'b0;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                           bit_reg <= 4'h0;
                           byte_reg <= byte_reg + 2'h1;
                           if (byte_reg == 2'h0) begin
                              tx_reg <= ptr_reg;
                           end else if (byte_reg == 2'h1) begin
                              tx_reg <= dat_reg;
                              if (rd_reg) begin
                                 st_reg <= LDP_M_RSTART;
                              end
                           end else if (byte_reg == 2'h3) begin
                              rdat_reg <= rx_reg;
                              st_reg <= LDP_M_STOP;
                           end else if (!rd_reg) begin
                              st_reg <= LDP_M_STOP;
                           end
                        end
                     end
                  endcase
               end
               LDP_M_STOP: begin
                  case (ph_reg)
                     2'h0: sda_reg <= 1'b0;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b1;
                     default: st_reg <= LDP_M_IDLE;
                  endcase
               end
               default: st_reg <= LDP_M_IDLE;
            endcase
         end
      end
   end
   assign bus.scl_o = scl_reg;
   assign bus.scl_oe = 1'b1;
   assign bus.sda_host_o = sda_reg;
   assign bus.sda_host_oe = !sda_reg;
endmodule

// *** core/ldp_target.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
// Function
// - SDA fall with SCL high starts session
// - SDA rise with SCL high stops session
// - Only master makes start and stop
// - Busy after start, idle after stop
// - Repeated start acts as plain start
// - SDA changes only while SCL low
// - Answer only address 1010011
// - Eighth bit: 0 write, 1 read
// - Write: pointer byte then data byte
// - Eight bits per byte, MSB first
// - Device pulls SDA low on ninth pulse
// - Master clocks and releases ninth pulse
// - Reset loads documented register values
// - Low three bits select operating mode
// - Mode bits mirrored torch and flash
// - Torch bits 5:3 set torch level
// - Torch bits 7:6 set indicator level
// - Indicator 00 lowest, 01 default, higher
// - Mode decode: off, ind, torch, flash, vout
module ldp_target
   import ldp_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   ldp_if.dev bus, // Serial link
   output ldp_pkg::ldp_mode_t mode, // Decoded operating mode
   output logic [2:0] torch_level, // Torch current level
   output logic [1:0] indicator_level, // Indicator current level
   output logic [7:0] flash_level, // Flash register
   output logic [7:0] timeout_limit, // Timeout register
   output logic [7:0] setup_one_out, // Setup register 1
   output logic [7:0] setup_two_out, // Setup register 2
   output logic [7:0] gpio_out, // GPIO register
   output logic [7:0] supply_out, // Supply monitor register
   output logic busy // Session open
);
   import ldp_pkg::*;
   typedef enum logic [2:0] {
      LDP_ST_IDLE = 3'h0,
      LDP_ST_ADDR = 3'h1,
      LDP_ST_PTR = 3'h2,
      LDP_ST_WDAT = 3'h3,
      LDP_ST_RDAT = 3'h4,
      LDP_ST_IGN = 3'h5
   } ldp_st_t;
   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_d_reg, sda_d_reg;
   ldp_st_t st_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg, ptr_reg, tx_reg;
   logic ack_reg, rd_reg, sda_oe_reg;
   logic [7:0] torch_reg, flash_reg, timeout_reg, fault_reg;
   logic [7:0] setup1_reg, setup2_reg, gpio_reg, supply_reg;
   logic busy_reg;
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire scl_rise = scl_s && !scl_d_reg;
   wire scl_fall = !scl_s && scl_d_reg;
   wire [7:0] byte_in = {shift_reg[6:0], sda_s};
   wire byte_done = scl_rise && (bit_reg == 4'h7) && !ack_reg;
   wire addr_hit = byte_in[7:1] == LDP_TARGET_ADDR;
   wire wr_en = byte_done && (st_reg == LDP_ST_WDAT);
   logic [7:0] rd_mux;
   always_comb begin
      case (ptr_reg)
         LDP_OFS_TORCH: rd_mux = torch_reg;
         LDP_OFS_FLASH: rd_mux = flash_reg;
         LDP_OFS_TIMEOUT: rd_mux = timeout_reg;
         LDP_OFS_FAULT: rd_mux = fault_reg;
         LDP_OFS_SETUP1: rd_mux = setup1_reg;
         LDP_OFS_SETUP2: rd_mux = setup2_reg;
         LDP_OFS_GPIO: rd_mux = gpio_reg;
         LDP_OFS_SUPPLY: rd_mux = supply_reg;
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], bus.scl};
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
      end else if (start_det) begin
         busy_reg <= 1'b1;
      end else if (stop_det) begin
         busy_reg <= 1'b0;
      end
   end
   // Protocol engine; SDA output moves only on SCL fall
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= LDP_ST_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         tx_reg <= 8'h00;
         ack_reg <= 1'b0;
         rd_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (start_det) begin
         st_reg <= LDP_ST_ADDR;
         bit_reg <= 4'h0;
         ack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (stop_det) begin
         st_reg <= LDP_ST_IDLE;
         sda_oe_reg <= 1'b0;
      end else if (st_reg != LDP_ST_IDLE && st_reg != LDP_ST_IGN) begin
         if (scl_rise && !ack_reg) begin
            shift_reg <= byte_in;
            bit_reg <= bit_reg + 4'h1;
         end
         if (byte_done) begin
            ack_reg <= 1'b1;
            case (st_reg)
               LDP_ST_ADDR: begin
                  rd_reg <= byte_in[0];
                  st_reg <= !addr_hit ? LDP_ST_IGN : (byte_in[0] ? LDP_ST_RDAT : LDP_ST_PTR);
                  if (!addr_hit) begin
                     ack_reg <= 1'b0;
                  end
               end
               LDP_ST_PTR: begin
                  ptr_reg <= byte_in;
                  st_reg <= LDP_ST_WDAT;
               end
               LDP_ST_WDAT: st_reg <= LDP_ST_WDAT;
               default: st_reg <= st_reg;
            endcase
         end
         if (scl_fall) begin
            if (ack_reg && bit_reg == 4'h8) begin
               bit_reg <= 4'h9;
               sda_oe_reg <= !rd_reg || st_reg != LDP_ST_RDAT || shift_reg[0] == 1'b1;
               if (rd_reg && st_reg == LDP_ST_RDAT) begin
                  sda_oe_reg <= 1'b1;
               end
            end else if (ack_reg && bit_reg == 4'h9) begin
               // Ack done; read phase loads the selected register MSB first
               ack_reg <= 1'b0;
               bit_reg <= 4'h0;
               if (st_reg == LDP_ST_RDAT) begin
                  tx_reg <= {rd_mux[6:0], 1'b0};
                  sda_oe_reg <= !rd_mux[7];
               end else begin
                  sda_oe_reg <= 1'b0;
               end
            end else if (st_reg == LDP_ST_RDAT && !ack_reg && bit_reg != 4'h0) begin
               tx_reg <= {tx_reg[6:0], 1'b0};
               sda_oe_reg <= (bit_reg == 4'h8) ? 1'b0 : !tx_reg[7];
            end
         end
         if (st_reg == LDP_ST_RDAT && scl_rise && bit_reg == 4'h7) begin
            ack_reg <= 1'b0;
         end
         // Master answer on a read byte: refusal ends the read, else the next byte follows
         if (st_reg == LDP_ST_RDAT && scl_rise && bit_reg == 4'h8) begin
            ack_reg <= !sda_s;
            bit_reg <= sda_s ? 4'h0 : 4'h9;
            st_reg <= sda_s ? LDP_ST_IGN : LDP_ST_RDAT;
         end
      end
   end
   // Register file; mode bits are shared between torch and flash
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         torch_reg <= LDP_RST_TORCH;
         flash_reg <= LDP_RST_FLASH;
         timeout_reg <= LDP_RST_TIMEOUT;
         fault_reg <= LDP_RST_FAULT;
         setup1_reg <= LDP_RST_SETUP1;
         setup2_reg <= LDP_RST_SETUP2;
         gpio_reg <= LDP_RST_GPIO;
         supply_reg <= LDP_RST_SUPPLY;
      end else if (wr_en) begin
         case (ptr_reg)
            LDP_OFS_TORCH: begin
               torch_reg <= byte_in;
               flash_reg[2:0] <= byte_in[2:0];
            end
            LDP_OFS_FLASH: begin
               flash_reg <= byte_in;
               torch_reg[2:0] <= byte_in[2:0];
            end
            LDP_OFS_TIMEOUT: timeout_reg <= byte_in;
            LDP_OFS_SETUP1: setup1_reg <= byte_in;
            LDP_OFS_SETUP2: setup2_reg <= byte_in;
            LDP_OFS_GPIO: gpio_reg <= byte_in;
            LDP_OFS_SUPPLY: supply_reg <= byte_in;
            default: fault_reg <= fault_reg; // Fault flags are read only
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= LDP_MODE_OFF;
         torch_level <= LDP_RST_TORCH[5:3];
         indicator_level <= 2'h1;
         flash_level <= LDP_RST_FLASH;
         timeout_limit <= LDP_RST_TIMEOUT;
         setup_one_out <= LDP_RST_SETUP1;
         setup_two_out <= LDP_RST_SETUP2;
         gpio_out <= LDP_RST_GPIO;
         supply_out <= LDP_RST_SUPPLY;
         busy <= 1'b0;
      end else begin
         mode <= ldp_mode_t'(torch_reg[LDP_MODE_LSB +: 3]);
         torch_level <= torch_reg[LDP_TLVL_LSB +: 3];
         indicator_level <= torch_reg[LDP_IND_LSB +: 2];
         flash_level <= flash_reg;
         timeout_limit <= timeout_reg;
         setup_one_out <= setup1_reg;
         setup_two_out <= setup2_reg;
         gpio_out <= gpio_reg;
         supply_out <= supply_reg;
         busy <= busy_reg;
      end
   end
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = sda_oe_reg;
endmodule

// *** inc/ldp_if.sv ***
`timescale 1ns/100ps
interface ldp_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   wire scl;
   wire sda;
   // Open drain: any enabled driver pulling low wins, otherwise pulled up
   assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
   assign sda = ((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o)) ? 1'b0 : 1'b1;
   modport host (output scl_o, scl_oe, sda_host_o, sda_host_oe, input scl, sda);
   modport dev (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface

// *** inc/ldp_pkg.sv ***
package ldp_pkg;
   localparam logic [6:0] LDP_TARGET_ADDR = 7'h53;
   localparam logic [7:0] LDP_OFS_GPIO = 8'h20;
   localparam logic [7:0] LDP_OFS_SUPPLY = 8'h80;
   localparam logic [7:0] LDP_OFS_TORCH = 8'hA0;
   localparam logic [7:0] LDP_OFS_FLASH = 8'hB0;
   localparam logic [7:0] LDP_OFS_TIMEOUT = 8'hC0;
   localparam logic [7:0] LDP_OFS_FAULT = 8'hD0;
   localparam logic [7:0] LDP_OFS_SETUP1 = 8'hE0;
   localparam logic [7:0] LDP_OFS_SETUP2 = 8'hF0;
   localparam logic [7:0] LDP_RST_GPIO = 8'h80;
   localparam logic [7:0] LDP_RST_SUPPLY = 8'hF0;
   localparam logic [7:0] LDP_RST_TORCH = 8'h50;
   localparam logic [7:0] LDP_RST_FLASH = 8'h68;
   localparam logic [7:0] LDP_RST_TIMEOUT = 8'h4F;
   localparam logic [7:0] LDP_RST_FAULT = 8'h40;
   localparam logic [7:0] LDP_RST_SETUP1 = 8'h42;
   localparam logic [7:0] LDP_RST_SETUP2 = 8'hF0;
   // Field positions within the torch register
   localparam int LDP_MODE_LSB = 0;
   localparam int LDP_TLVL_LSB = 3;
   localparam int LDP_IND_LSB = 6;
   typedef enum logic [2:0] {
      LDP_MODE_OFF = 3'h0,
      LDP_MODE_IND = 3'h1,
      LDP_MODE_TORCH = 3'h2,
      LDP_MODE_FLASH = 3'h3,
      LDP_MODE_VOUT = 3'h4
   } ldp_mode_t;
   // Host side: half link clock period in system clocks (400 ns at 100 ns)
   localparam int LDP_SYS_NS = 100;
   localparam int LDP_LINK_NS = 800;
   localparam logic [7:0] LDP_HALF_CYC = 8'((LDP_LINK_NS / 2) / LDP_SYS_NS);
   // Host command register offsets
   localparam logic [1:0] LDP_CMD_CTRL = 2'h0;
   localparam logic [1:0] LDP_CMD_STAT = 2'h1;
   localparam logic [1:0] LDP_CMD_RDAT = 2'h2;
endpackage

// *** sim/ldp_checker.sv ***
`timescale 1ns/100ps
module ldp_checker (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   input wire logic scl_o, // Host clock drive
   input wire logic scl_oe, // Host clock enable
   input wire logic sda_host_o, // Host data drive
   input wire logic sda_host_oe, // Host data enable
   input wire logic sda_dev_o, // Device data drive
   input wire logic sda_dev_oe, // Device data enable
   input wire logic scl, // Resolved clock
   input wire logic sda // Resolved data
);
   import ldp_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Bit count within each nine-bit byte since the last start, seen on the wires only
   logic scl_q_reg, sda_q_reg, first_reg;
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         first_reg <= 1'b0;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
      end else begin
         scl_q_reg <= scl;
         sda_q_reg <= sda;
         if (scl && scl_q_reg && sda_q_reg && !sda) begin
            first_reg <= 1'b1;
            cnt_reg <= 4'h0;
         end else if (scl && !scl_q_reg) begin
            cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
            first_reg <= first_reg && cnt_reg != 4'h8;
            sh_reg <= {sh_reg[6:0], sda};
         end
      end
   end
   wire addr_ack_slot = scl && !scl_q_reg && first_reg && cnt_reg == 4'h8;

   dev_stable_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("device data moved while clock high");
   high_change_a: assert property (scl && $past(scl) && $changed(sda) |-> !sda_dev_oe && !$past(sda_dev_oe))
      else $error("device made a condition on the line");
   dev_low_a: assert property (addr_ack_slot && sh_reg[7:1] == LDP_TARGET_ADDR |-> !sda)
      else $error("device did not acknowledge its address");
   host_rel_a: assert property (sda_dev_oe && scl |-> !sda_host_oe || sda_host_o)
      else $error("host held data during device bit");
   dev_bound_a: assert property ($rose(sda_dev_oe) |-> ##[1:100] !sda_dev_oe)
      else $error("device drive not released in time");
   scl_low_a: assert property ($fell(scl) |-> !scl [*4])
      else $error("clock low phase too short");
   scl_high_a: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high phase too short");
   start_dev_a: assert property (scl && $fell(sda) |-> !sda_dev_oe && !$past(sda_dev_oe))
      else $error("start not made by host");
   idle_quiet_a: assert property (scl [*8] |-> !sda_dev_oe)
      else $error("device drives an idle line");

   start_c: cover property (scl && $fell(sda));
   ack_c: cover property ($rose(sda_dev_oe) && !scl);
   stop_c: cover property (scl && $rose(sda));
endmodule

// *** sim/led_driver_i2c_register_port_test.sv ***
`timescale 1ns/100ps
module led_driver_i2c_register_port_test;
   import ldp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] cmd_addr = 2'h0;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [15:0] cmd_rdata;
   ldp_mode_t mode;
   logic [2:0] torch_level;
   logic [1:0] indicator_level;
   logic [7:0] flash_level, timeout_limit, setup_one_out, setup_two_out, gpio_out, supply_out;
   logic busy;
   int err_count = 0;
   int num_checks = 0;
   int starts = 0;
   int stops = 0;
   int mon_bits = 0;
   int mon_byte = 0;
   logic [7:0] mon_sh = 8'h00;
   logic [7:0] mon_addr = 8'h00;
   logic mon_ack = 1'b1;

   ldp_if link();
   ldp_master i_ldp_master (.sys_clk(sys_clk), .rst_n(rst_n), .bus(link), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   ldp_target i_ldp_target (.sys_clk(sys_clk), .rst_n(rst_n), .bus(link), .mode(mode),
      .torch_level(torch_level), .indicator_level(indicator_level), .flash_level(flash_level),
      .timeout_limit(timeout_limit), .setup_one_out(setup_one_out), .setup_two_out(setup_two_out),
      .gpio_out(gpio_out), .supply_out(supply_out), .busy(busy));
   ldp_checker i_ldp_checker (.sys_clk(sys_clk), .rst_n(rst_n), .scl_o(link.scl_o), .scl_oe(link.scl_oe),
      .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // Wire watcher, blind to both ends' internals
   always @(negedge link.sda) begin
      if (link.scl === 1'b1) begin
         starts++;
         mon_bits = 0;
         mon_byte = 0;
      end
   end
   always @(posedge link.sda) begin
      if (link.scl === 1'b1) begin
         stops++;
      end
   end
   always @(posedge link.scl) begin
      if (mon_bits == 8) begin
         if (mon_byte == 0) begin
            mon_ack = link.sda;
         end
         mon_bits = 0;
         mon_byte++;
      end else begin
         mon_sh = {mon_sh[6:0], link.sda};
         mon_bits++;
         if (mon_bits == 8 && mon_byte == 0) begin
            mon_addr = mon_sh;
         end
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmd_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
   endtask

   task automatic cmd_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      #1;
      d = cmd_rdata;
   endtask

   task automatic wait_idle();
      logic [15:0] s;
      s = 16'h0001;
      for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) begin
         cmd_read(LDP_CMD_STAT, s);
      end
      if (s[0] !== 1'b0) begin
         err_count++;
      end
   endtask

   // Pointer bits 7:1 ride on bits 14:8; bit 0 is always 0
   task automatic link_op(input logic rd, input logic [7:0] ptr, input logic [7:0] d, output logic [15:0] r);
      logic [15:0] s;
      int s0;
      int p0;
      s0 = starts;
      p0 = stops;
      cmd_write(LDP_CMD_CTRL, {rd, ptr[7:1], d});
      cmd_read(LDP_CMD_STAT, s);
      check(16'(s[0]), 16'h1);
      for (int i = 0; i < 50 && busy !== 1'b1; i++) begin
         @(posedge sys_clk);
      end
      check(16'(busy), 16'h1);
      wait_idle();
      for (int i = 0; i < 50 && busy !== 1'b0; i++) begin
         @(posedge sys_clk);
      end
      check(16'(busy), 16'h0);
      check(16'(mon_addr), 16'({LDP_TARGET_ADDR, rd}));
      check(16'(mon_ack), 16'h0);
      check(16'(starts - s0), rd ? 16'h2 : 16'h1);
      check(16'(stops - p0), 16'h1);
      cmd_read(LDP_CMD_STAT, s);
      check(16'(s[1]), 16'h0);
      cmd_read(LDP_CMD_RDAT, r);
   endtask

   function automatic logic [7:0] reg_view(input logic [7:0] p);
      case (p)
         LDP_OFS_TIMEOUT: return timeout_limit;
         LDP_OFS_SETUP1: return setup_one_out;
         LDP_OFS_SETUP2: return setup_two_out;
         LDP_OFS_GPIO: return gpio_out;
         default: return 8'h00;
      endcase
   endfunction

   task automatic t_reset();
      check(16'(mode), 16'(LDP_MODE_OFF));
      check(16'(mode), 16'(LDP_RST_TORCH[2:0]));
      check(16'(torch_level), 16'(LDP_RST_TORCH[5:3]));
      check(16'(indicator_level), 16'h1);
      check(16'(indicator_level), 16'(LDP_RST_TORCH[7:6]));
      check(16'(flash_level), 16'(LDP_RST_FLASH));
      check(16'(timeout_limit), 16'(LDP_RST_TIMEOUT));
      check(16'(setup_one_out), 16'(LDP_RST_SETUP1));
      check(16'(setup_two_out), 16'(LDP_RST_SETUP2));
      check(16'(gpio_out), 16'(LDP_RST_GPIO));
      check(16'(supply_out), 16'(LDP_RST_SUPPLY));
      check(16'({busy, link.scl, link.sda}), 16'h3);
   endtask

   task automatic t_writes();
      logic [7:0] ptrs [4] = '{8'hC0, 8'hE0, 8'hF0, 8'h20};
      logic [7:0] vals [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h81};
      logic [15:0] r;
      for (int k = 0; k < 4; k++) begin
         link_op(1'b0, ptrs[k], vals[k], r);
         check(16'(reg_view(ptrs[k])), 16'(vals[k]));
         link_op(1'b1, ptrs[k], 8'h00, r);
         check(16'(r[7:0]), 16'(vals[k]));
      end
   endtask

   // Second order lands while the first is on the wire and must be dropped
   task automatic t_refuse();
      cmd_write(LDP_CMD_CTRL, {1'b0, LDP_OFS_TIMEOUT[7:1], 8'h11});
      cmd_write(LDP_CMD_CTRL, {1'b0, LDP_OFS_TIMEOUT[7:1], 8'h22});
      wait_idle();
      check(16'(timeout_limit), 16'h0011);
   endtask

   task automatic t_fault();
      logic [15:0] r;
      link_op(1'b1, LDP_OFS_FAULT, 8'h00, r);
      check(16'(r[7:0]), 16'(LDP_RST_FAULT));
      link_op(1'b0, LDP_OFS_FAULT, 8'hFF, r);
      link_op(1'b1, LDP_OFS_FAULT, 8'h00, r);
      check(16'(r[7:0]), 16'(LDP_RST_FAULT));
   endtask

   // Mode bits written through either register show in both
   task automatic t_mirror();
      logic [15:0] r;
      link_op(1'b0, LDP_OFS_TORCH, 8'hE3, r);
      check(16'(mode), 16'(LDP_MODE_FLASH));
      check(16'(torch_level), 16'h4);
      check(16'(indicator_level), 16'h3);
      check(16'(flash_level), 16'({LDP_RST_FLASH[7:3], 3'h3}));
      link_op(1'b0, LDP_OFS_FLASH, 8'h94, r);
      check(16'(mode), 16'(LDP_MODE_VOUT));
      check(16'(flash_level), 16'h0094);
      link_op(1'b1, LDP_OFS_TORCH, 8'h00, r);
      check(r, 16'h00E4);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_writes();
      t_refuse();
      t_fault();
      t_mirror();
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      err_count++;
      report_and_stop();
   end
endmodule
